//--- verilog/esp_pkg.sv
/*
  Constants shared by the enhanced serial port: register offsets, field
  positions, reset values, mode codes, divide counts and state encodings.
  Assumes a 32-bit APB bus with byte addresses, one register per word.
*/
package esp_pkg;

  localparam int ESP_ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_SERIAL_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFS_DATA_REG = 8'h04;
  localparam logic [7:0] OFS_SERIAL_STATUS_REG = 8'h08;
  localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h0C;
  localparam logic [7:0] OFS_BAUD_DIVISOR_HIGH = 8'h10;
  localparam logic [7:0] OFS_BAUD_DIVISOR_LOW = 8'h14;
  localparam logic [7:0] OFS_BAUD_SOURCE_REG = 8'h18;

  // Field positions.
  localparam int CTL_MODE_SEL_HI = 7;
  localparam int CTL_MODE_SEL_LO = 6;
  localparam int CTL_RX_ENABLE = 4;
  localparam int CTL_TX_NINTH_BIT = 3;
  localparam int CTL_RX_NINTH_BIT = 2;
  localparam int CTL_TX_DONE = 1;
  localparam int CTL_RX_DONE = 0;
  localparam int PWR_RATE_DOUBLE_SEL = 7;
  localparam int PWR_FRAMING_FLAG_SEL = 6;
  localparam int STA_FRAME_ERR = 0;
  localparam int STA_TX_BUSY = 1;
  localparam int STA_RX_BUSY = 2;
  localparam int SRC_USE_DIVISOR = 0;

  // Reset values.
  localparam logic [7:0] RST_SERIAL_CONTROL_REG = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL_REG = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
  localparam logic RST_BAUD_SOURCE = 1'b0;

  // Modes.
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;

  // Timing counts in clock cycles or oversample ticks.
  localparam logic [3:0] SHIFT_PHASE_LAST = 4'hF;
  localparam logic [3:0] SHIFT_SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_CENTRE = 4'h7;
  localparam logic [3:0] DATA_BIT_LAST = 4'h7;

  typedef enum logic [5:0] {
    ESP_TX_IDLE = 6'h01,
    ESP_TX_START = 6'h02,
    ESP_TX_DATA = 6'h04,
    ESP_TX_NINTH = 6'h08,
    ESP_TX_STOP = 6'h10,
    ESP_TX_SHIFT = 6'h20
  } esp_tx_state_t;

  typedef enum logic [4:0] {
    ESP_RX_IDLE = 5'h01,
    ESP_RX_START = 5'h02,
    ESP_RX_DATA = 5'h04,
    ESP_RX_NINTH = 5'h08,
    ESP_RX_STOP = 5'h10
  } esp_rx_state_t;

endpackage

//--- verilog/esp_sync.sv
/*
  Three-stage synchroniser for a pin input with agreement filter.
  Assumes the input is asynchronous to clk_sys_i.
*/
module esp_sync (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pin and clean level.
  input wire logic pin_i,
  output logic level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // The level only moves once the last two stages agree.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_o <= 1'b1;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end

endmodule

//--- verilog/esp_baud_gen.sv
/*
  Oversample tick generator for the asynchronous modes.
  Assumes the timer overflow pulse is one cycle wide on clk_sys_i.
*/
module esp_baud_gen (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Configuration.
  input wire logic [1:0] mode_i,
  input wire logic use_divisor_i,
  input wire logic rate_double_sel_i,
  input wire logic [15:0] divisor_i,
  input wire logic timer_one_overflow_i,
  // Sixteen ticks per bit.
  output logic tick_o
);
  import esp_pkg::*;

  logic [15:0] div_cnt_r;
  logic half_r;
  logic div_hit;
  logic ovf_tick;

  assign div_hit = (div_cnt_r >= divisor_i);
  assign ovf_tick = timer_one_overflow_i & (rate_double_sel_i | half_r);

  // The divisor counter runs on the CPU clock at all times.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_cnt_r <= 16'h0000;
    end else if (ce_i) begin
      div_cnt_r <= div_hit ? 16'h0000 : div_cnt_r + 16'h0001;
    end
  end

  // Halving flop serves both the fixed rate and the timer overflow path.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      half_r <= 1'b0;
    end else if (ce_i) begin
      if (mode_i == MODE_FIXED9 || timer_one_overflow_i) begin
        half_r <= ~half_r;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (mode_i == MODE_FIXED9) begin
        tick_o <= rate_double_sel_i | half_r;
      end else if (use_divisor_i) begin
        tick_o <= div_hit;
      end else begin
        tick_o <= ovf_tick;
      end
    end
  end

endmodule

//--- verilog/esp_uart.sv
/*
  Enhanced serial port: APB register file, transmitter with shift-clock
  mode, and oversampling asynchronous receiver.
  Assumes one clock, a synchronous high reset, and a one-cycle timer
  overflow pulse on the same clock.
*/
// Register access over APB and the placing of the registers are this design's own decisions.
// How it works
// - Timer 2 overflow never serves as a bit-rate source.
// - Bit rate comes from fixed division, timer overflow or divisor generator.
// - Shift mode moves 8 bits LSB first on data pin; output pin clocks.
// - Shift clock runs at one sixteenth of the CPU clock.
// - Async 8-bit frame: low start, 8 data LSB first, high stop.
// - Async 8-bit mode stores the received stop bit as rx ninth bit.
// - Async 8-bit rate comes from timer overflow or divisor generator.
// - 9-bit frame: start, 8 data LSB first, ninth bit, stop.
// - Transmitted ninth bit is the software-written tx ninth bit.
// - Received ninth bit goes to rx ninth bit; stop bit is dropped.
// - Fixed 9-bit mode runs at clock/16 or clock/32 by rate double.
// - Variable 9-bit mode equals fixed one except its rate source.
// - Divisor generator uses the high and low divisor bytes joined.
// - Timer overflow is halved while rate double select is clear.
// - Divisor generator is clocked by the CPU clock.
// - Framing error is reported in the status register.
// - Control bit 7 shows framing error when framing flag select is set.
module esp_uart (
  // Clock, reset, enable.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [esp_pkg::ESP_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Rate source.
  input wire logic timer_one_overflow_i,
  // Serial pins.
  output logic txd_o,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_n_o
);
  import esp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic mode_sel_hi_r;
  logic mode_sel_lo_r;
  logic rx_en_r;
  logic tx_ninth_bit_r;
  logic rx_ninth_bit_r;
  logic tx_done_r;
  logic rx_done_r;
  logic frame_err_r;
  logic rate_double_sel_r;
  logic framing_flag_sel_r;
  logic use_divisor_r;
  logic [7:0] baud_divisor_high_r;
  logic [7:0] baud_divisor_low_r;
  logic [7:0] rx_buf_r;
  logic [1:0] mode;
  logic tick;
  logic rx_s;
  logic rx_s_d_r;
  logic acc;
  logic wr;
  logic wr_ctl;
  logic wr_data;
  logic [7:0] rd_val;
  logic rd_err;

  esp_tx_state_t tx_st_r;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_sub_r;
  logic [3:0] sh_ph_r;
  logic sh_rx_r;
  logic tx_fin_r;
  logic m0_rx_fin_r;
  logic tx_bit_end;
  logic m0_rx_go;

  esp_rx_state_t rx_st_r;
  logic [7:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_sub_r;
  logic rx_ninth_r;
  logic rx_fin_r;
  logic rx_fin_bit_r;
  logic fe_set_r;
  logic rx_sample;

  assign mode = {mode_sel_hi_r, mode_sel_lo_r};

  ////////////////////////////////////////////////////////////////////////
  esp_sync u_rx_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(rxd_i),
    .level_o(rx_s)
  );

  esp_baud_gen u_baud (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mode_i(mode),
    .use_divisor_i(use_divisor_r),
    .rate_double_sel_i(rate_double_sel_r),
    .divisor_i({baud_divisor_high_r, baud_divisor_low_r}),
    .timer_one_overflow_i(timer_one_overflow_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave: every access answers in the cycle after setup.
  assign acc = psel_i & penable_i & pready_o;
  assign wr = acc & pwrite_i;
  assign wr_ctl = wr && (paddr_i == OFS_SERIAL_CONTROL_REG);
  assign wr_data = wr && (paddr_i == OFS_DATA_REG);

  always_comb begin
    rd_val = 8'h00;
    rd_err = 1'b0;
    if (paddr_i == OFS_SERIAL_CONTROL_REG) begin
      rd_val = {framing_flag_sel_r ? frame_err_r : mode_sel_hi_r,
                mode_sel_lo_r, 1'b0, rx_en_r, tx_ninth_bit_r,
                rx_ninth_bit_r, tx_done_r, rx_done_r};
    end else if (paddr_i == OFS_DATA_REG) begin
      rd_val = rx_buf_r;
    end else if (paddr_i == OFS_SERIAL_STATUS_REG) begin
      rd_val[STA_FRAME_ERR] = frame_err_r;
      rd_val[STA_TX_BUSY] = (tx_st_r != ESP_TX_IDLE);
      rd_val[STA_RX_BUSY] = (rx_st_r != ESP_RX_IDLE);
    end else if (paddr_i == OFS_POWER_CONTROL_REG) begin
      rd_val[PWR_RATE_DOUBLE_SEL] = rate_double_sel_r;
      rd_val[PWR_FRAMING_FLAG_SEL] = framing_flag_sel_r;
    end else if (paddr_i == OFS_BAUD_DIVISOR_HIGH) begin
      rd_val = baud_divisor_high_r;
    end else if (paddr_i == OFS_BAUD_DIVISOR_LOW) begin
      rd_val = baud_divisor_low_r;
    end else if (paddr_i == OFS_BAUD_SOURCE_REG) begin
      rd_val[SRC_USE_DIVISOR] = use_divisor_r;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & rd_err;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? {24'h00_0000, rd_val}
                                                    : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_sel_hi_r <= RST_SERIAL_CONTROL_REG[CTL_MODE_SEL_HI];
      mode_sel_lo_r <= RST_SERIAL_CONTROL_REG[CTL_MODE_SEL_LO];
      rx_en_r <= RST_SERIAL_CONTROL_REG[CTL_RX_ENABLE];
      tx_ninth_bit_r <= RST_SERIAL_CONTROL_REG[CTL_TX_NINTH_BIT];
      rate_double_sel_r <= RST_POWER_CONTROL_REG[PWR_RATE_DOUBLE_SEL];
      framing_flag_sel_r <= RST_POWER_CONTROL_REG[PWR_FRAMING_FLAG_SEL];
      baud_divisor_high_r <= RST_BAUD_DIVISOR;
      baud_divisor_low_r <= RST_BAUD_DIVISOR;
      use_divisor_r <= RST_BAUD_SOURCE;
    end else if (ce_i) begin
      if (wr_ctl) begin
        if (!framing_flag_sel_r) begin
          mode_sel_hi_r <= pwdata_i[CTL_MODE_SEL_HI];
        end
        mode_sel_lo_r <= pwdata_i[CTL_MODE_SEL_LO];
        rx_en_r <= pwdata_i[CTL_RX_ENABLE];
        tx_ninth_bit_r <= pwdata_i[CTL_TX_NINTH_BIT];
      end
      if (wr && paddr_i == OFS_POWER_CONTROL_REG) begin
        rate_double_sel_r <= pwdata_i[PWR_RATE_DOUBLE_SEL];
        framing_flag_sel_r <= pwdata_i[PWR_FRAMING_FLAG_SEL];
      end
      if (wr && paddr_i == OFS_BAUD_DIVISOR_HIGH) begin
        baud_divisor_high_r <= pwdata_i[7:0];
      end
      if (wr && paddr_i == OFS_BAUD_DIVISOR_LOW) begin
        baud_divisor_low_r <= pwdata_i[7:0];
      end
      if (wr && paddr_i == OFS_BAUD_SOURCE_REG) begin
        use_divisor_r <= pwdata_i[SRC_USE_DIVISOR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event flags: a hardware set wins over a software clear.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_done_r <= RST_SERIAL_CONTROL_REG[CTL_TX_DONE];
      rx_done_r <= RST_SERIAL_CONTROL_REG[CTL_RX_DONE];
      rx_ninth_bit_r <= RST_SERIAL_CONTROL_REG[CTL_RX_NINTH_BIT];
      frame_err_r <= 1'b0;
    end else if (ce_i) begin
      if (tx_fin_r) begin
        tx_done_r <= 1'b1;
      end else if (wr_ctl) begin
        tx_done_r <= pwdata_i[CTL_TX_DONE];
      end
      if (rx_fin_r || m0_rx_fin_r) begin
        rx_done_r <= 1'b1;
      end else if (wr_ctl) begin
        rx_done_r <= pwdata_i[CTL_RX_DONE];
      end
      if (rx_fin_r) begin
        rx_ninth_bit_r <= rx_fin_bit_r;
      end else if (wr_ctl) begin
        rx_ninth_bit_r <= pwdata_i[CTL_RX_NINTH_BIT];
      end
      if (fe_set_r) begin
        frame_err_r <= 1'b1;
      end else if ((wr_ctl && framing_flag_sel_r &&
                    !pwdata_i[CTL_MODE_SEL_HI]) ||
                   (wr && paddr_i == OFS_SERIAL_STATUS_REG &&
                    pwdata_i[STA_FRAME_ERR])) begin
        frame_err_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_buf_r <= 8'h00;
    end else if (ce_i) begin
      if (rx_fin_r) begin
        rx_buf_r <= rx_sh_r;
      end else if (m0_rx_fin_r) begin
        rx_buf_r <= tx_sh_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter, also the shift-register engine in mode 0.
  assign tx_bit_end = tick && (tx_sub_r == OVS_LAST);
  assign m0_rx_go = (mode == MODE_SHIFT) && rx_en_r && !rx_done_r &&
                    !m0_rx_fin_r && !wr_data;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_st_r <= ESP_TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 4'h0;
      tx_sub_r <= 4'h0;
      sh_ph_r <= 4'h0;
      sh_rx_r <= 1'b0;
      tx_fin_r <= 1'b0;
      m0_rx_fin_r <= 1'b0;
      txd_o <= 1'b1;
      rxd_o <= 1'b1;
      rxd_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      tx_fin_r <= 1'b0;
      m0_rx_fin_r <= 1'b0;
      if (tick) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      case (tx_st_r)
        ESP_TX_IDLE: begin
          tx_sub_r <= 4'h0;
          tx_cnt_r <= 4'h0;
          sh_ph_r <= 4'h0;
          if (wr_data) begin
            tx_sh_r <= pwdata_i[7:0];
            if (mode == MODE_SHIFT) begin
              tx_st_r <= ESP_TX_SHIFT;
              sh_rx_r <= 1'b0;
              txd_o <= 1'b0;
              rxd_o <= pwdata_i[0];
              rxd_oe_n_o <= 1'b0;
            end else begin
              tx_st_r <= ESP_TX_START;
              txd_o <= 1'b0;
            end
          end else if (m0_rx_go) begin
            tx_st_r <= ESP_TX_SHIFT;
            sh_rx_r <= 1'b1;
            txd_o <= 1'b0;
          end
        end
        ESP_TX_START: begin
          if (tx_bit_end) begin
            tx_st_r <= ESP_TX_DATA;
            txd_o <= tx_sh_r[0];
          end
        end
        ESP_TX_DATA: begin
          if (tx_bit_end) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            if (tx_cnt_r != DATA_BIT_LAST) begin
              txd_o <= tx_sh_r[1];
            end else if (mode[1]) begin
              tx_st_r <= ESP_TX_NINTH;
              txd_o <= tx_ninth_bit_r;
            end else begin
              tx_st_r <= ESP_TX_STOP;
              txd_o <= 1'b1;
            end
          end
        end
        ESP_TX_NINTH: begin
          if (tx_bit_end) begin
            tx_st_r <= ESP_TX_STOP;
            txd_o <= 1'b1;
          end
        end
        ESP_TX_STOP: begin
          if (tx_bit_end) begin
            tx_st_r <= ESP_TX_IDLE;
            tx_fin_r <= 1'b1;
          end
        end
        ESP_TX_SHIFT: begin
          // Clock low for eight cycles, high for eight.
          sh_ph_r <= sh_ph_r + 4'h1;
          txd_o <= (sh_ph_r >= SHIFT_SAMPLE_PHASE) &&
                   (sh_ph_r != SHIFT_PHASE_LAST);
          if (sh_rx_r && sh_ph_r == SHIFT_SAMPLE_PHASE) begin
            tx_sh_r <= {rx_s, tx_sh_r[7:1]};
          end
          if (sh_ph_r == SHIFT_PHASE_LAST) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (!sh_rx_r) begin
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              rxd_o <= tx_sh_r[1];
            end
            if (tx_cnt_r == DATA_BIT_LAST) begin
              tx_st_r <= ESP_TX_IDLE;
              txd_o <= 1'b1;
              rxd_o <= 1'b1;
              rxd_oe_n_o <= 1'b1;
              tx_fin_r <= ~sh_rx_r;
              m0_rx_fin_r <= sh_rx_r;
            end
          end
        end
        default: begin
          tx_st_r <= ESP_TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver.
  assign rx_sample = tick && (rx_sub_r == OVS_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_st_r <= ESP_RX_IDLE;
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 4'h0;
      rx_sub_r <= 4'h0;
      rx_ninth_r <= 1'b0;
      rx_fin_r <= 1'b0;
      rx_fin_bit_r <= 1'b0;
      fe_set_r <= 1'b0;
      rx_s_d_r <= 1'b1;
    end else if (ce_i) begin
      rx_s_d_r <= rx_s;
      rx_fin_r <= 1'b0;
      fe_set_r <= 1'b0;
      if (tick) begin
        rx_sub_r <= rx_sub_r + 4'h1;
      end
      case (rx_st_r)
        ESP_RX_IDLE: begin
          rx_sub_r <= 4'h0;
          rx_cnt_r <= 4'h0;
          if (mode != MODE_SHIFT && rx_en_r && rx_s_d_r && !rx_s) begin
            rx_st_r <= ESP_RX_START;
          end
        end
        ESP_RX_START: begin
          if (tick && rx_sub_r == OVS_CENTRE) begin
            rx_sub_r <= 4'h0;
            rx_st_r <= rx_s ? ESP_RX_IDLE : ESP_RX_DATA;
          end
        end
        ESP_RX_DATA: begin
          if (rx_sample) begin
            rx_sh_r <= {rx_s, rx_sh_r[7:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == DATA_BIT_LAST) begin
              rx_st_r <= mode[1] ? ESP_RX_NINTH : ESP_RX_STOP;
            end
          end
        end
        ESP_RX_NINTH: begin
          if (rx_sample) begin
            rx_ninth_r <= rx_s;
            rx_st_r <= ESP_RX_STOP;
          end
        end
        ESP_RX_STOP: begin
          if (rx_sample) begin
            rx_st_r <= ESP_RX_IDLE;
            rx_fin_r <= 1'b1;
            rx_fin_bit_r <= mode[1] ? rx_ninth_r : rx_s;
            fe_set_r <= ~rx_s;
          end
        end
        default: begin
          rx_st_r <= ESP_RX_IDLE;
        end
      endcase
    end
  end

endmodule

//--- test/esp_props.sv
/*
  Checker for the serial port top: bus answer and shift-clock timing.
  Assumes ce_i stays high while a bus transfer runs.
*/
module esp_props (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [esp_pkg::ESP_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins.
  input wire logic txd_o,
  input wire logic rxd_o,
  input wire logic rxd_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import esp_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  setup_answer_a: assert property (psel_i && !penable_i && ce_i
    |=> pready_o) else $error("no answer after setup");
  answer_place_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  answer_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  error_map_a: assert property (pready_o |-> pslverr_o ==
    (paddr_i > OFS_BAUD_SOURCE_REG || paddr_i[1:0] != 2'b00))
    else $error("error flag wrong for address");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  shift_period_a: assert property ($rose(txd_o) && !rxd_oe_n_o
    |=> !$rose(txd_o) [*8] ##8 ($rose(txd_o) || rxd_oe_n_o))
    else $error("shift clock period wrong");
  shift_data_a: assert property ($rose(txd_o) && !rxd_oe_n_o
    |-> $stable(rxd_o)) else $error("data moved at clock rise");
  shift_len_a: assert property ($fell(rxd_oe_n_o)
    |-> ##120 !rxd_oe_n_o ##[1:9] rxd_oe_n_o)
    else $error("shift transfer length wrong");
endmodule
bind esp_uart esp_props i_props (.clk_sys_i, .rst_i, .ce_i, .psel_i,
  .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .txd_o, .rxd_o,
  .rxd_oe_n_o);

//--- test/esp_peer.sv
/*
  Far-side model: an asynchronous peer that sends and samples frames,
  and an 8-bit shift register moved by the shift clock.
  Assumes a pull-up on the data line, so idle reads high.
*/
module esp_peer (
  // Clock.
  input wire logic clk_sys_i,
  // Pins.
  input wire logic txd_i,
  input wire logic line_i,
  input wire logic shift_on_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sreg = 8'h00;
  logic alvl = 1'b1;
  logic txd_q = 1'b1;
  assign line_o = shift_on_i ? sreg[0] : alvl;
  ////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    txd_q <= txd_i;
    if (shift_on_i && txd_i && !txd_q)
      sreg <= {line_i, sreg[7:1]};
  end
  task load(input logic [7:0] v);
    @(posedge clk_sys_i) sreg <= v;
  endtask
  // Start bit, then b LSB first, each bit per cycles long.
  task send(input logic [9:0] b, input int n, input int per);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys_i) alvl <= (i == 0) ? 1'b0 : b[i-1];
      repeat (per - 1) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i) alvl <= 1'b1;
  endtask
  task grab(input int n, input int per, output logic [10:0] b,
            output logic to);
    int k;
    k = 0;
    b = 11'h000;
    while (txd_i !== 1'b0 && k < 9000) begin
      @(posedge clk_sys_i);
      k++;
    end
    to = (k >= 9000);
    repeat (per / 2) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      b[i] = txd_i;
      repeat (per) @(posedge clk_sys_i);
    end
  endtask
endmodule

//--- test/esp_uart_tb_top.sv
/*
  Self-checking bench for the serial port: bus tasks and frame checks in
  every mode. Assumes esp_peer on the pins and esp_props bound.
*/
module esp_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import esp_pkg::*;
  localparam logic [7:0] CTL = OFS_SERIAL_CONTROL_REG;
  localparam logic [7:0] DAT = OFS_DATA_REG;
  localparam logic [7:0] STA = OFS_SERIAL_STATUS_REG;
  localparam logic [7:0] PWR = OFS_POWER_CONTROL_REG;
  localparam logic [7:0] DHI = OFS_BAUD_DIVISOR_HIGH;
  localparam logic [7:0] DLO = OFS_BAUD_DIVISOR_LOW;
  localparam logic [7:0] SRC = OFS_BAUD_SOURCE_REG;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, tmr = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, shift_on = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, txd, rxd_o, oe_n, peer_lvl, rxd_pin;
  logic [10:0] f;
  int n_errors = 0, checks_done = 0;
  int nc;
  logic [7:0] ofs [6] = '{CTL, STA, PWR, DHI, DLO, SRC};
  assign rxd_pin = oe_n ? peer_lvl : rxd_o;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tmr <= ~tmr;
  esp_uart i_dut (.clk_sys_i(clk_sys), .rst_i(rst), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .timer_one_overflow_i(tmr),
    .txd_o(txd), .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_n_o(oe_n));
  esp_peer i_peer (.clk_sys_i(clk_sys), .txd_i(txd), .line_i(rxd_pin),
    .shift_on_i(shift_on), .line_o(peer_lvl));
  ////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tmo;
    n_errors++;
    tally_and_finish();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, {24'h0, x});
  endtask
  task till(input logic v, input int lim, output int n);
    n = 0;
    while (txd !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) tmo();
  endtask
  // Width of the first data bit, which is high and followed by a low.
  task bitw(input int x);
    int n;
    till(1'b0, 99, n);
    till(1'b1, 9000, n);
    till(1'b0, 9000, n);
    chk(32'(n), 32'(x));
  endtask
  task frame(input int n, input int per, input logic [10:0] x);
    logic to;
    i_peer.grab(n, per, f, to);
    if (to) tmo();
    chk(32'(f), 32'(x));
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(8'h1C, 8'h00);
    chk(32'(e), 32'h1);
    $display("test 1 end");
    wr(SRC, 8'h01);
    wr(DHI, 8'h01);
    wr(DLO, 8'h00);
    wr(CTL, 8'h40);
    wr(DAT, 8'h01);
    bitw(16 * 257);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(DHI, 8'h00);
    $display("test 2 end");
    wr(SRC, 8'h01);
    wr(CTL, 8'h50);
    wr(DAT, 8'hA5);
    frame(10, 16, {1'b1, 8'hA5, 1'b0});
    i_peer.send(10'({1'b1, 8'h3C}), 9, 16);
    rd(DAT, 8'h3C);
    rd(CTL, 8'h57);
    wr(CTL, 8'h50);
    i_peer.send(10'({1'b0, 8'hC3}), 9, 16);
    rd(STA, 8'h01);
    rd(CTL, 8'h51);
    wr(PWR, 8'h40);
    rd(CTL, 8'hD1);
    wr(STA, 8'h01);
    rd(CTL, 8'h51);
    wr(PWR, 8'h00);
    $display("test 3 end");
    for (int i = 0; i < 2; i++) begin
      wr(PWR, i ? 8'h00 : 8'h80);
      wr(CTL, i ? 8'h80 : 8'h88);
      wr(DAT, 8'h5A);
      frame(11, 16 << i, {1'b1, ~i[0], 8'h5A, 1'b0});
    end
    $display("test 4 end");
    wr(CTL, 8'hD0);
    i_peer.send({2'b10, 8'h69}, 10, 16);
    rd(DAT, 8'h69);
    rd(CTL, 8'hD1);
    $display("test 5 end");
    wr(SRC, 8'h00);
    wr(CTL, 8'h40);
    for (int i = 0; i < 2; i++) begin
      wr(PWR, i ? 8'h00 : 8'h80);
      wr(DAT, 8'h01);
      bitw(32 << i);
      repeat (320 << i) @(posedge clk_sys);
    end
    // Ten frozen cycles inside a data bit must not count towards its width.
    wr(DAT, 8'h01);
    till(1'b0, 99, nc);
    till(1'b1, 9000, nc);
    ce <= 1'b0;
    repeat (10) @(posedge clk_sys);
    ce <= 1'b1;
    till(1'b0, 9000, nc);
    chk(32'(nc), 32'h40);
    repeat (640) @(posedge clk_sys);
    $display("test 6 end");
    shift_on <= 1'b1;
    wr(CTL, 8'h00);
    wr(DAT, 8'h96);
    repeat (140) @(posedge clk_sys);
    chk(32'(i_peer.sreg), 32'h96);
    i_peer.load(8'h3B);
    wr(CTL, 8'h10);
    repeat (140) @(posedge clk_sys);
    rd(DAT, 8'h3B);
    $display("test 7 end");
    tally_and_finish();
  end
endmodule
